// >>> verilog/trf_pkg.sv
// package for the tag request frame parser: register map, flag positions, crc constants
// assumes a classic wishbone master on the same clock as the parser
package trf_pkg;
  // ==========================================
  // register offsets (byte addresses)
  localparam logic [7:0] TRF_OFS_CTRL = 8'h00;
  localparam logic [7:0] TRF_OFS_STATUS = 8'h04;
  localparam logic [7:0] TRF_OFS_FLAGS = 8'h08;
  localparam logic [7:0] TRF_OFS_CMD = 8'h0C;
  localparam logic [7:0] TRF_OFS_UID_LO = 8'h10;
  localparam logic [7:0] TRF_OFS_UID_HI = 8'h14;
  localparam logic [7:0] TRF_OFS_RXLEN = 8'h18;
  localparam logic [7:0] TRF_OFS_RXDATA = 8'h1C;
  localparam logic [7:0] TRF_OFS_TXDATA = 8'h20;
  // ==========================================
  // request flag bit positions (b1 is bit 0)
  localparam int TRF_FB_SUBCAR = 0;
  localparam int TRF_FB_RATE = 1;
  localparam int TRF_FB_INVENTORY = 2;
  localparam int TRF_FB_EXTEND = 3;
  localparam int TRF_FB_SELECT = 4;
  localparam int TRF_FB_ADDRESS = 5;
  localparam int TRF_FB_OPTION = 6;
  localparam int TRF_FB_RESERVED = 7;
  // ==========================================
  // status bit positions
  localparam int TRF_SB_VALID = 0;
  localparam int TRF_SB_CRC_ERR = 1;
  localparam int TRF_SB_FLAG_ERR = 2;
  localparam int TRF_SB_UID_MISS = 3;
  localparam int TRF_SB_LEN_ERR = 4;
  localparam int TRF_SB_TX_BUSY = 5;
  // ==========================================
  // frame check constants
  localparam logic [15:0] TRF_CRC_PRESET = 16'hFFFF;
  localparam logic [15:0] TRF_CRC_POLY = 16'h8408;
  localparam logic [15:0] TRF_CRC_RESIDUE = 16'hF0B8;
  localparam logic [63:0] TRF_UID_RESET = 64'h0000_0000_0000_0000;
  localparam int TRF_UID_BYTES = 8;
  // ==========================================
  // carrier for a received byte from the bit decoder
  typedef struct packed {
    logic sof;
    logic eof;
    logic valid;
    logic [7:0] data;
  } trf_rx_s;
  // decoded reply settings
  typedef struct packed {
    logic two_subcarriers;
    logic high_rate;
    logic single_slot;
    logic option;
  } trf_reply_s;
endpackage : trf_pkg

// >>> verilog/trf_parser.sv
// tag request frame parser: collects a request, checks crc and flags, gates the reply
// assumes a bit decoder delivering whole bytes lsb-first and a reply serializer downstream
//
// Local design decisions: the placing of the registers and register access over Wishbone.
`timescale 1ns/10ps
module trf_parser
  import trf_pkg::*;
#(
  // largest request kept, check bytes included
  parameter int MAX_BYTES = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  // wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // received bytes from the bit decoder
  input trf_rx_s rx_i,
  input wire logic rx_bit_frac_i,
  // reply byte stream to the serializer
  output logic tx_valid_o,
  output logic [7:0] tx_data_o,
  output logic tx_last_o,
  input wire logic tx_ready_i,
  output trf_reply_s reply_o
);
  // receive states: idle until the first start, recv while bytes arrive,
  // done holds the verdict until the next start delimiter
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RECV = 2'b01,
    ST_DONE = 2'b10
  } trf_state_e;

  // ==========================================
  // crc step over one byte, lsb first
  // shared by the receive check and the reply, so both ends agree bit for bit
  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c;
    for (int i = 0; i < 8; i++) begin
      if (r[0] ^ d[i]) begin
        r = (r >> 1) ^ TRF_CRC_POLY;
      end else begin
        r = r >> 1;
      end
    end
    return r;
  endfunction : crc_byte

  // request buffer and its byte count; len_r stops at MAX_BYTES on overflow
  trf_state_e state_r;
  logic [7:0] buf_r [MAX_BYTES];
  logic [5:0] len_r;
  logic [15:0] crc_r;
  logic [15:0] tx_crc_r;
  logic [63:0] uid_r;
  logic [7:0] status_r;
  logic reply_en_r;
  // reply buffer filled by software, streamed with a fresh check value
  logic [7:0] tx_buf_r [MAX_BYTES];
  logic [5:0] tx_len_r;
  logic [5:0] tx_idx_r;
  logic [1:0] tx_phase_r;
  logic tx_go;
  logic [4:0] rd_idx_r;
  logic [7:0] flags;
  logic flags_bad;
  logic uid_hit;
  logic wb_req;

  // the flags byte is always the first byte after the start
  assign flags = buf_r[0];
  // a request counts once; the cycle that shows ack takes nothing new
  assign wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;

  // ==========================================
  // flag checks on the buffered request
  // b5 is select outside inventory and family filter inside it;
  // neither is supported, so either meaning silences the tag
  always_comb begin
    flags_bad = flags[TRF_FB_EXTEND] | flags[TRF_FB_RESERVED];
    if (flags[TRF_FB_INVENTORY]) begin
      flags_bad = flags_bad | flags[TRF_FB_SELECT];
    end else begin
      flags_bad = flags_bad | flags[TRF_FB_SELECT];
    end
  end

  // uid sits after flags and command, lowest byte first
  // only read for addressed non-inventory frames, whose bytes 2 to 9 hold it
  always_comb begin
    uid_hit = 1'b1;
    for (int i = 0; i < TRF_UID_BYTES; i++) begin
      if (buf_r[i + 2] != uid_r[i*8 +: 8]) begin
        uid_hit = 1'b0;
      end
    end
  end

  // ==========================================
  // receive state machine
  // a start in any state restarts the frame, so a cut frame never
  // leaks its bytes or its verdict into the next one
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      state_r <= ST_IDLE;
      len_r <= '0;
      crc_r <= TRF_CRC_PRESET;
      status_r <= '0;
    end else begin
      case (state_r)
        ST_IDLE: begin
          if (rx_i.sof) begin
            state_r <= ST_RECV;
            len_r <= '0;
            crc_r <= TRF_CRC_PRESET;
            status_r <= '0;
          end
        end
        ST_RECV: begin
          if (rx_i.sof) begin
            len_r <= '0;
            crc_r <= TRF_CRC_PRESET;
            status_r <= '0;
          end else if (rx_i.eof) begin
            state_r <= ST_DONE;
            // whole frame checked at once, nothing acted on before here
            // an overflowed frame keeps its length error whatever the check says
            if (rx_bit_frac_i || len_r < 6'd4 || status_r[TRF_SB_LEN_ERR]) begin
              status_r[TRF_SB_LEN_ERR] <= 1'b1;
            // the residue test covers data and check bytes in one pass
            end else if (crc_r != TRF_CRC_RESIDUE) begin
              status_r[TRF_SB_CRC_ERR] <= 1'b1;
            end else if (flags_bad) begin
              status_r[TRF_SB_FLAG_ERR] <= 1'b1;
            end else if (!flags[TRF_FB_INVENTORY] && flags[TRF_FB_ADDRESS] && !uid_hit) begin
              status_r[TRF_SB_UID_MISS] <= 1'b1;
            end else begin
              status_r[TRF_SB_VALID] <= 1'b1;
            end
          end else if (rx_i.valid) begin
            // bytes past MAX_BYTES feed the check but are not kept
            if (len_r < 6'(MAX_BYTES)) begin
              len_r <= len_r + 6'd1;
            end else begin
              status_r[TRF_SB_LEN_ERR] <= 1'b1;
            end
            crc_r <= crc_byte(crc_r, rx_i.data);
          end
        end
        // done waits for the next start; a stray end is ignored
        ST_DONE: begin
          if (rx_i.sof) begin
            state_r <= ST_RECV;
            len_r <= '0;
            crc_r <= TRF_CRC_PRESET;
            status_r <= '0;
          end
        end
        default: state_r <= ST_IDLE;
      endcase
    end
  end

  // byte buffer holding the request
  // no reset: contents only count once a valid verdict marks them
  always_ff @(posedge ref_clk) begin
    if (state_r == ST_RECV && rx_i.valid && !rx_i.sof && !rx_i.eof &&
        len_r < 6'(MAX_BYTES)) begin
      buf_r[len_r[4:0]] <= rx_i.data;
    end
  end

  // ==========================================
  // reply settings latched at each end delimiter seen in recv, tracking the last request;
  // they take effect only when a valid verdict lets a reply start
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      reply_o <= '0;
    end else if (state_r == ST_RECV && rx_i.eof) begin
      reply_o.two_subcarriers <= flags[TRF_FB_SUBCAR];
      reply_o.high_rate <= flags[TRF_FB_RATE];
      reply_o.single_slot <= flags[TRF_FB_INVENTORY] & flags[TRF_FB_ADDRESS];
      reply_o.option <= flags[TRF_FB_OPTION];
    end
  end

  // ==========================================
  // register writes: uid, reply buffer, reply start
  // a write lands at the taking edge, one cycle before ack is seen;
  // byte enables matter for the identifier words and CTRL byte 0 only
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      uid_r <= TRF_UID_RESET;
      tx_len_r <= '0;
      reply_en_r <= 1'b0;
    end else begin
      // start request is a one-cycle pulse
      reply_en_r <= 1'b0;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          // bit 0 starts a reply, bits 6:1 give its length in bytes
          TRF_OFS_CTRL: begin
            if (wb_sel_i[0]) begin
              reply_en_r <= wb_dat_i[0];
              tx_len_r <= wb_dat_i[6:1];
            end
          end
          TRF_OFS_UID_LO: begin
            for (int b = 0; b < 4; b++) begin
              if (wb_sel_i[b]) uid_r[b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
          end
          TRF_OFS_UID_HI: begin
            for (int b = 0; b < 4; b++) begin
              if (wb_sel_i[b]) uid_r[32 + b*8 +: 8] <= wb_dat_i[b*8 +: 8];
            end
          end
          default: begin
          end
        endcase
      end
    end
  end

  // reply byte buffer written through a window with an auto index
  // reading RXDATA moves the same index, so software writes CTRL
  // first to rewind it before filling the reply buffer
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      rd_idx_r <= '0;
    end else if (wb_req && wb_adr_i == TRF_OFS_CTRL && wb_we_i) begin
      rd_idx_r <= '0;
    end else if (wb_req && (wb_adr_i == TRF_OFS_TXDATA || wb_adr_i == TRF_OFS_RXDATA)) begin
      if (wb_we_i && wb_adr_i == TRF_OFS_TXDATA) begin
        tx_buf_r[rd_idx_r] <= wb_dat_i[7:0];
      end
      rd_idx_r <= rd_idx_r + 5'd1;
    end
  end

  // ==========================================
  // reply serializer: buffer bytes, then inverted crc low byte first
  // phase 0 idle, 1 buffer bytes, 2 check low byte, 3 check high byte;
  // a start without a valid verdict is dropped, so nothing modulates
  assign tx_go = reply_en_r && state_r == ST_DONE && status_r[TRF_SB_VALID] &&
                 tx_len_r != 6'd0;
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      tx_phase_r <= 2'd0;
      tx_idx_r <= '0;
      tx_crc_r <= TRF_CRC_PRESET;
    end else begin
      case (tx_phase_r)
        2'd0: begin
          if (tx_go) begin
            tx_phase_r <= 2'd1;
            tx_idx_r <= '0;
            tx_crc_r <= TRF_CRC_PRESET;
          end
        end
        2'd1: begin
          if (tx_ready_i) begin
            tx_crc_r <= crc_byte(tx_crc_r, tx_buf_r[tx_idx_r[4:0]]);
            tx_idx_r <= tx_idx_r + 6'd1;
            // after the last buffer byte the check bytes follow
            if (tx_idx_r + 6'd1 == tx_len_r) tx_phase_r <= 2'd2;
          end
        end
        2'd2: if (tx_ready_i) tx_phase_r <= 2'd3;
        // high check byte carries last; idle follows once it is taken
        default: if (tx_ready_i) tx_phase_r <= 2'd0;
      endcase
    end
  end

  // reply stream outputs
  // phase and index only move on ready, so a stalled byte stands unchanged
  always_comb begin
    tx_valid_o = tx_phase_r != 2'd0;
    tx_last_o = tx_phase_r == 2'd3;
    case (tx_phase_r)
      2'd1: tx_data_o = tx_buf_r[tx_idx_r[4:0]];
      2'd2: tx_data_o = ~tx_crc_r[7:0];
      2'd3: tx_data_o = ~tx_crc_r[15:8];
      default: tx_data_o = 8'h00;
    endcase
  end

  // ==========================================
  // wishbone read mux and single-cycle ack
  // ack follows the taken request by one cycle and lasts one cycle;
  // read data stands only beside ack and is zero otherwise
  always_ff @(posedge ref_clk) begin
    if (!rst_b) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_req;
      wb_dat_o <= '0;
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          TRF_OFS_STATUS: wb_dat_o <= {24'h0000_00, 2'b00, tx_phase_r != 2'd0, status_r[4:0]};
          TRF_OFS_FLAGS: wb_dat_o <= {24'h0000_00, flags};
          TRF_OFS_CMD: wb_dat_o <= {24'h0000_00, buf_r[1]};
          TRF_OFS_UID_LO: wb_dat_o <= uid_r[31:0];
          TRF_OFS_UID_HI: wb_dat_o <= uid_r[63:32];
          TRF_OFS_RXLEN: wb_dat_o <= {26'h000_0000, len_r};
          TRF_OFS_RXDATA: wb_dat_o <= {24'h0000_00, buf_r[rd_idx_r]};
          default: wb_dat_o <= '0;
        endcase
      end
    end
  end
endmodule : trf_parser

// >>> test/trf_parser_props.sv
// checker for the frame parser port relations
// assumes it is bound onto trf_parser, one clock domain
`timescale 1ns/10ps
module trf_parser_props
  import trf_pkg::*;
#(
  parameter int MAX_BYTES = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input trf_rx_s rx_i,
  input wire logic tx_valid_o,
  input wire logic [7:0] tx_data_o,
  input wire logic tx_last_o,
  input wire logic tx_ready_i,
  input trf_reply_s reply_o
);
  // ========
  // bus answer
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  a_ack_one_pulse:
    assert property (wb_ack_o |=> !wb_ack_o) else $error("ack too long");
  a_ack_after_req:
    assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o) else $error("ack late");
  a_ack_has_req:
    assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i)) else $error("stray ack");
  a_rdata_idle_zero:
    assert property (!wb_ack_o |-> wb_dat_o == 32'h0000_0000) else $error("data outside ack");
  // ========
  // reply stream
  a_tx_needs_start:
    assert property ($rose(tx_valid_o) |-> $past(wb_ack_o && wb_we_i)) else $error("reply unasked");
  a_tx_hold_stall:
    assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_data_o))
      else $error("byte lost in stall");
  a_tx_last_ends:
    assert property (tx_valid_o && tx_last_o && tx_ready_i |=> !tx_valid_o) else $error("overrun");
  a_reply_stable:
    assert property (!rx_i.eof |=> $stable(reply_o)) else $error("reply settings moved");
  c_reply_done: cover property (tx_valid_o && tx_last_o && tx_ready_i);
  c_frame_end: cover property (rx_i.eof);
  c_bus_read: cover property (wb_ack_o && !wb_we_i);
endmodule : trf_parser_props

bind trf_parser trf_parser_props #(.MAX_BYTES(MAX_BYTES)) u_props (
  .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .rx_i(rx_i),
  .tx_valid_o(tx_valid_o), .tx_data_o(tx_data_o), .tx_last_o(tx_last_o),
  .tx_ready_i(tx_ready_i), .reply_o(reply_o)
);

// >>> test/trf_reader_model.sv
// reader-side partner: feeds request bytes, takes reply bytes with stalls
// assumes the parser clock and a bench that calls send
`timescale 1ns/10ps
module trf_reader_model
  import trf_pkg::*;
(
  input wire logic ref_clk,
  output trf_rx_s rx_o,
  output logic frac_o,
  input wire logic tx_valid_i,
  input wire logic [7:0] tx_data_i,
  input wire logic tx_last_i,
  output logic tx_ready_o
);
  logic [8:0] got_q[$];
  // quiet lines at start
  initial begin
    rx_o = '0;
    frac_o = 1'b0;
    tx_ready_o = 1'b0;
  end
  // one frame: start, bytes in order, end; data inverted off the strobe
  task automatic send(input logic [7:0] f[$], input logic frac);
    @(posedge ref_clk);
    rx_o <= '{1'b1, 1'b0, 1'b0, ~rx_o.data};
    foreach (f[i]) begin
      @(posedge ref_clk);
      rx_o <= '{1'b0, 1'b0, 1'b1, f[i]};
      @(posedge ref_clk);
      rx_o <= '{1'b0, 1'b0, 1'b0, ~f[i]};
    end
    @(posedge ref_clk);
    rx_o <= '{1'b0, 1'b1, 1'b0, ~rx_o.data};
    frac_o <= frac;
    @(posedge ref_clk);
    rx_o <= '{1'b0, 1'b0, 1'b0, ~rx_o.data};
    frac_o <= 1'b0;
  endtask : send
  // reply taker, stalls one cycle in three
  always @(posedge ref_clk) begin
    if (tx_valid_i && tx_ready_o) got_q.push_back({tx_last_i, tx_data_i});
    tx_ready_o <= ($urandom % 3) != 0;
  end
endmodule : trf_reader_model

// >>> test/tb.sv
// testbench: corner and random request frames, status readback, reply stream
// assumes the reader model and the bound checker
`timescale 1ns/10ps
module tb
  import trf_pkg::*;
;
  logic ref_clk = 1'b0, rst_b = 1'b0, wb_cyc = 1'b0, wb_stb = 1'b0, wb_we = 1'b0;
  logic [7:0] wb_adr = 8'h00;
  logic [31:0] wb_wdat = 32'h0000_0000, wb_rdat;
  logic wb_ack, tx_valid, tx_last, tx_ready, rx_frac;
  logic [7:0] tx_data;
  logic [63:0] my_uid;
  trf_rx_s rx;
  trf_reply_s reply;
  int num_errors = 0, samples_checked = 0, cycles = 0;
  // ========
  // clock and hang guard
  initial forever #50 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 20000) begin
      num_errors++;
      end_of_test();
    end
  end
  trf_parser #(.MAX_BYTES(32)) dut (
    .ref_clk(ref_clk), .rst_b(rst_b), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we),
    .wb_adr_i(wb_adr), .wb_sel_i(4'hF), .wb_dat_i(wb_wdat), .wb_dat_o(wb_rdat),
    .wb_ack_o(wb_ack), .rx_i(rx), .rx_bit_frac_i(rx_frac), .tx_valid_o(tx_valid),
    .tx_data_o(tx_data), .tx_last_o(tx_last), .tx_ready_i(tx_ready), .reply_o(reply)
  );
  trf_reader_model rdr (
    .ref_clk(ref_clk), .rx_o(rx), .frac_o(rx_frac), .tx_valid_i(tx_valid),
    .tx_data_i(tx_data), .tx_last_i(tx_last), .tx_ready_o(tx_ready)
  );
  // ========
  // helpers
  task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  // classic single bus cycle, held until ack
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] d,
                    output logic [31:0] q);
    @(posedge ref_clk);
    {wb_cyc, wb_stb, wb_we, wb_adr, wb_wdat} <= {2'b11, we, adr, d};
    do @(posedge ref_clk); while (wb_ack !== 1'b1);
    q = wb_rdat;
    {wb_cyc, wb_stb} <= 2'b00;
  endtask : wb
  // inverted reflected crc, preset all ones
  function automatic logic [15:0] crc16(input logic [7:0] f[$]);
    logic [15:0] c;
    c = TRF_CRC_PRESET;
    foreach (f[i]) begin
      c ^= 16'(f[i]);
      repeat (8) c = c[0] ? (c >> 1) ^ TRF_CRC_POLY : c >> 1;
    end
    return ~c;
  endfunction : crc16
  // one request, its status, then a reply attempt
  task automatic one_frame(input int k);
    logic [7:0] f[$], e[$], fl;
    logic [15:0] c;
    logic [31:0] q;
    logic bad, miss, ok, fe;
    fl = 8'($urandom) & 8'h67;
    bad = (k == 4) || (k > 6 && $urandom % 8 == 0);
    miss = (k == 6) || ($urandom % 4 == 0);
    case (k)
      0: fl[3] = 1'b1;
      1: fl[7] = 1'b1;
      2: fl[4:2] = 3'b100;
      3: fl[4:2] = 3'b101;
      6: fl[5:2] = 4'b1000;
      default: ;
    endcase
    f = {fl, 8'($urandom)};
    if (!fl[2] && fl[5]) for (int i = 0; i < TRF_UID_BYTES; i++)
      f.push_back(8'((my_uid ^ 64'(miss)) >> (8 * i)));
    repeat ($urandom % 3) f.push_back(8'($urandom));
    c = crc16(f) ^ (16'(bad) << 8);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    fe = !bad && k != 5 && (fl[3] || fl[4] || fl[7]);
    ok = !bad && k != 5 && !fl[3] && !fl[4] && !fl[7] && !(!fl[2] && fl[5] && miss);
    rdr.send(f, k == 5);
    repeat (2) @(posedge ref_clk);
    wb(1'b0, TRF_OFS_STATUS, 32'h0, q);
    check("valid", 32'(ok), 32'(q[TRF_SB_VALID]));
    check("crc err", 32'(bad), 32'(q[TRF_SB_CRC_ERR]));
    check("flag err", 32'(fe), 32'(q[TRF_SB_FLAG_ERR]));
    check("uid miss", 32'(!bad && k != 5 && !fe && !fl[2] && fl[5] && miss),
          32'(q[TRF_SB_UID_MISS]));
    check("len err", 32'(k == 5), 32'(q[TRF_SB_LEN_ERR]));
    check("tx busy", 32'h0000_0000, 32'(q[TRF_SB_TX_BUSY]));
    if (ok) begin
      wb(1'b0, TRF_OFS_FLAGS, 32'h0, q);
      check("flags", 32'(fl), q);
      wb(1'b0, TRF_OFS_CMD, 32'h0, q);
      check("cmd", 32'(f[1]), q);
      wb(1'b0, TRF_OFS_RXLEN, 32'h0, q);
      check("rxlen", 32'(f.size()), q);
      for (int i = 0; i < 2; i++) begin
        wb(1'b0, TRF_OFS_RXDATA, 32'h0, q);
        check("rxdata", 32'(f[i]), q);
      end
      check("reply", 32'({fl[0], fl[1], fl[6]}),
            32'({reply.two_subcarriers, reply.high_rate, reply.option}));
      if (fl[2]) check("slots", 32'(fl[5]), 32'(reply.single_slot));
      e = {8'($urandom), 8'($urandom)};
      wb(1'b1, TRF_OFS_CTRL, 32'h0, q);
      foreach (e[i]) wb(1'b1, TRF_OFS_TXDATA, 32'(e[i]), q);
      c = crc16(e);
      e.push_back(c[7:0]);
      e.push_back(c[15:8]);
    end
    rdr.got_q.delete();
    wb(1'b1, TRF_OFS_CTRL, 32'h0000_0005, q);
    for (int i = 0; i < 200 && rdr.got_q.size() < e.size(); i++) @(posedge ref_clk);
    repeat (20) @(posedge ref_clk);
    check("count", 32'(e.size()), 32'(rdr.got_q.size()));
    foreach (e[i]) check("byte", 32'({i == e.size() - 1, e[i]}), 32'(rdr.got_q[i]));
    $display("frame %0d done", k);
  endtask : one_frame
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : end_of_test
  // ========
  // main sequence
  initial begin
    logic [31:0] q;
    void'($urandom(48));
    my_uid = {$urandom, $urandom};
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'b1;
    wb(1'b0, 8'h40, 32'h0, q);
    check("unmapped", 32'h0, q);
    wb(1'b1, TRF_OFS_UID_LO, my_uid[31:0], q);
    wb(1'b1, TRF_OFS_UID_HI, my_uid[63:32], q);
    wb(1'b0, TRF_OFS_UID_HI, 32'h0, q);
    check("uid hi", my_uid[63:32], q);
    wb(1'b0, TRF_OFS_UID_LO, 32'h0, q);
    check("uid lo", my_uid[31:0], q);
    $display("register test done");
    for (int k = 0; k < 24; k++) one_frame(k);
    end_of_test();
  end
endmodule : tb
